//--- ext_bus_regs.vh
`ifndef EXT_BUS_REGS_VH
`define EXT_BUS_REGS_VH
`define RESET_VECTOR 20'h00000
`define INT_CODE_LIMIT 20'h08000
`define ST_IDLE 5'h01
`define ST_ADDR 5'h02
`define ST_STRB 5'h04
`define ST_WAIT 5'h08
`define ST_DONE 5'h10
`define KIND_CODE 2'h0
`define KIND_READ 2'h1
`define KIND_WRITE 2'h2
`define ALE_CYCLES 4'h1
`define STRB_CYCLES 4'h2
`define BOOT_EXTERNAL 1'h0
`define SYNC_DEPTH 2'h3
`define COUNT_LAST 4'h1
`endif

//--- external_bus_boot_select.v
`timescale 1ns/100ps
// Function
// - while reset is low, all pins and control state take default values.
// - first code fetch after reset uses the reset vector address.
// - address-latch strobe high tells the external latch to capture the address.
// - address-latch strobe pulses only for real external bus cycles.
// - external code fetch drives the code read strobe low.
// - code read strobe active only on external code fetches.
// - external data reads use their own data read strobe.
// - external low-byte data writes use a dedicated low-byte write strobe.
// - reset, code read, data read, write strobes and boot select are active low.
// - boot select sampled once it has passed the three synchroniser stages after reset release, then held for all later execution.
// - sampled 0 means every code fetch goes to external memory.
// - sampled 1 means internal code below the limit, external at and above it.
// - once the boot value is sampled and held, the boot select pin serves as the wait input.
// - wait held high stretches an external cycle until it is released.
`include "ext_bus_regs.vh"

module external_bus_boot_select #(
    parameter ADDR_W = 20,
    parameter DATA_W = 8
) (
    input wire clock,
    input wire nrst,
    input wire reqValid,
    input wire [1:0] reqKind,
    input wire [ADDR_W-1:0] reqAddr,
    input wire [DATA_W-1:0] reqWdata,
    input wire bootMemorySelect_n,
    input wire [DATA_W-1:0] busIn,
    output reg reqReady,
    output reg reqInternal,
    output reg respValid,
    output reg [DATA_W-1:0] respData,
    output reg [ADDR_W-1:0] resetVector,
    output reg bootExternal,
    output reg addrLatchStrobe,
    output reg codeReadStrobe_n,
    output reg dataReadStrobe_n,
    output reg dataLowWriteStrobe_n,
    output reg [ADDR_W-1:0] busAddr,
    output reg [DATA_W-1:0] busOut,
    output reg busOutEnable
);

////////////////////////////////////////////////////////////////////////////////
// pin synchroniser: three flops, change accepted when second and third agree
wire [`SYNC_DEPTH:0] pinChain;
wire pinS2;
wire pinS3;
reg pinLevel;
reg [1:0] settle;
reg sampled;
reg bootSel;
genvar stage;

assign pinChain[0] = bootMemorySelect_n;
assign pinS2 = pinChain[`SYNC_DEPTH-1];
assign pinS3 = pinChain[`SYNC_DEPTH];

generate
    for (stage = 0; stage < `SYNC_DEPTH; stage = stage + 1) begin : g_sync
        reg flop;
        always @(posedge clock or negedge nrst) begin
            if (!nrst)
                flop <= 1'h1;
            else
                flop <= pinChain[stage];
        end
        assign pinChain[stage + 1] = flop;
    end
endgenerate

// resets to the idle high level of the pin
always @(posedge clock or negedge nrst) begin
    if (!nrst)
        pinLevel <= 1'h1;
    else if (pinS2 == pinS3)
        pinLevel <= pinS3;
end

////////////////////////////////////////////////////////////////////////////////
// boot choice: the stages hold their reset level until the pin has passed all
// three, so sampling any earlier would latch that level instead of the pin
always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
        settle <= 2'h0;
        sampled <= 1'h0;
        bootSel <= 1'h1;
    end else begin
        if (settle != `SYNC_DEPTH)
            settle <= settle + 2'h1;
        if (settle == `SYNC_DEPTH && !sampled && pinS2 == pinS3) begin
            bootSel <= pinS3;
            sampled <= 1'h1;
        end
    end
end

// wait meaning of the pin only once the boot value is held
wire waitActive = sampled && pinLevel;

////////////////////////////////////////////////////////////////////////////////
// access decode
function isInternal;
    input [1:0] fnKind;
    input [ADDR_W-1:0] fnAddr;
    input fnSel;
    begin
        isInternal = (fnKind == `KIND_CODE) && (fnSel != `BOOT_EXTERNAL)
            && (fnAddr < `INT_CODE_LIMIT);
    end
endfunction

// strobe level for one kind: low only when the cycle is of that kind
function strobeLevel;
    input [1:0] cycleKind;
    input [1:0] strobeKind;
    begin
        strobeLevel = (cycleKind == strobeKind) ? 1'h0 : 1'h1;
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// bus cycle sequencer
localparam [4:0] STATE_IDLE = `ST_IDLE;
localparam [4:0] STATE_ADDR = `ST_ADDR;
localparam [4:0] STATE_STRB = `ST_STRB;
localparam [4:0] STATE_WAIT = `ST_WAIT;
localparam [4:0] STATE_DONE = `ST_DONE;

reg [4:0] state;
reg [1:0] kind;
reg [3:0] count;

always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
        state <= STATE_IDLE;
        kind <= `KIND_CODE;
        count <= 4'h0;
        reqReady <= 1'h0;
        reqInternal <= 1'h0;
        respValid <= 1'h0;
        respData <= {DATA_W{1'b0}};
        resetVector <= `RESET_VECTOR;
        bootExternal <= 1'h0;
        addrLatchStrobe <= 1'h0;
        codeReadStrobe_n <= 1'h1;
        dataReadStrobe_n <= 1'h1;
        dataLowWriteStrobe_n <= 1'h1;
        busAddr <= {ADDR_W{1'b0}};
        busOut <= {DATA_W{1'b0}};
        busOutEnable <= 1'h0;
    end else begin
        respValid <= 1'h0;
        reqInternal <= 1'h0;
        bootExternal <= (bootSel == `BOOT_EXTERNAL);
        case (state)
            STATE_IDLE: begin
                // requests held off until the boot choice is known
                reqReady <= sampled;
                if (sampled && reqReady && reqValid) begin
                    reqReady <= 1'h0;
                    if (isInternal(reqKind, reqAddr, bootSel)) begin
                        // internal fetch: no strobe at all
                        reqInternal <= 1'h1;
                        respValid <= 1'h1;
                        state <= STATE_DONE;
                    end else begin
                        kind <= reqKind;
                        busAddr <= reqAddr;
                        busOut <= reqWdata;
                        busOutEnable <= (reqKind == `KIND_WRITE);
                        addrLatchStrobe <= 1'h1;
                        count <= `ALE_CYCLES;
                        state <= STATE_ADDR;
                    end
                end
            end
            STATE_ADDR: begin
                if (count > `COUNT_LAST) begin
                    count <= count - 4'h1;
                end else begin
                    // falling edge here is where the latch captures
                    addrLatchStrobe <= 1'h0;
                    codeReadStrobe_n <= strobeLevel(kind, `KIND_CODE);
                    dataReadStrobe_n <= strobeLevel(kind, `KIND_READ);
                    dataLowWriteStrobe_n <= strobeLevel(kind, `KIND_WRITE);
                    count <= `STRB_CYCLES;
                    state <= STATE_STRB;
                end
            end
            STATE_STRB: begin
                if (count > `COUNT_LAST)
                    count <= count - 4'h1;
                else
                    state <= STATE_WAIT;
            end
            STATE_WAIT: begin
                // wait comes through the synchroniser, so it must already be high on the edge that takes the request, before the strobe
                if (!waitActive) begin
                    respData <= busIn;
                    respValid <= 1'h1;
                    codeReadStrobe_n <= 1'h1;
                    dataReadStrobe_n <= 1'h1;
                    dataLowWriteStrobe_n <= 1'h1;
                    busOutEnable <= 1'h0;
                    state <= STATE_DONE;
                end
            end
            STATE_DONE: begin
                state <= STATE_IDLE;
            end
            default: begin
                state <= STATE_IDLE;
            end
        endcase
    end
end

endmodule // external_bus_boot_select

//--- ext_bus_chk.sv
`timescale 1ns/100ps
`include "ext_bus_regs.vh"
module ext_bus_chk (
    input wire clock,
    input wire nrst,
    input wire reqValid,
    input wire [1:0] reqKind,
    input wire [19:0] reqAddr,
    input wire reqReady,
    input wire reqInternal,
    input wire respValid,
    input wire bootExternal,
    input wire bootMemorySelect_n,
    input wire addrLatchStrobe,
    input wire codeReadStrobe_n,
    input wire dataReadStrobe_n,
    input wire dataLowWriteStrobe_n,
    input wire busOutEnable
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    wire tk = reqValid && reqReady;
    wire ex = bootExternal || reqKind != `KIND_CODE || reqAddr >= `INT_CODE_LIMIT;
    ////////////////////////////////////////////////////////////////
    sequence s_strb; (!codeReadStrobe_n || !dataReadStrobe_n || !dataLowWriteStrobe_n) [*2]; endsequence
    property p_ale; addrLatchStrobe |=> !addrLatchStrobe ##0 s_strb; endproperty
    a_ale: assert property (p_ale) else $error("address strobe not followed by strobe");
    property p_one; $onehot0({!codeReadStrobe_n, !dataReadStrobe_n, !dataLowWriteStrobe_n}); endproperty
    a_one: assert property (p_one) else $error("two strobes at once");
    property p_rd; tk && reqKind == `KIND_READ |=> ##1 !dataReadStrobe_n && codeReadStrobe_n; endproperty
    a_rd: assert property (p_rd) else $error("data read strobe missing");
    property p_wr; tk && reqKind == `KIND_WRITE |=> ##1 !dataLowWriteStrobe_n && busOutEnable; endproperty
    a_wr: assert property (p_wr) else $error("write strobe missing");
    property p_ext; tk && ex |=> addrLatchStrobe; endproperty
    a_ext: assert property (p_ext) else $error("external cycle without address strobe");
    property p_int; tk && !ex |=> !addrLatchStrobe ##[0:1] reqInternal; endproperty
    a_int: assert property (p_int) else $error("internal fetch went external");
    property p_boot; $past(reqReady) |-> $stable(bootExternal); endproperty
    a_boot: assert property (p_boot) else $error("boot value changed");
    property p_wait; bootMemorySelect_n [*6] |-> !respValid || reqInternal; endproperty
    a_wait: assert property (p_wait) else $error("cycle ended during wait");
endmodule // ext_bus_chk
bind external_bus_boot_select ext_bus_chk u_chk (
    .clock(clock),
    .nrst(nrst),
    .reqValid(reqValid),
    .reqKind(reqKind),
    .reqAddr(reqAddr),
    .reqReady(reqReady),
    .reqInternal(reqInternal),
    .respValid(respValid),
    .bootExternal(bootExternal),
    .bootMemorySelect_n(bootMemorySelect_n),
    .addrLatchStrobe(addrLatchStrobe),
    .codeReadStrobe_n(codeReadStrobe_n),
    .dataReadStrobe_n(dataReadStrobe_n),
    .dataLowWriteStrobe_n(dataLowWriteStrobe_n),
    .busOutEnable(busOutEnable)
);

//--- ext_mem.sv
`timescale 1ns/100ps
module ext_mem (
    input wire clock,
    input wire addrLatchStrobe,
    input wire [19:0] busAddr,
    input wire codeReadStrobe_n,
    input wire dataReadStrobe_n,
    input wire dataLowWriteStrobe_n,
    input wire [7:0] busOut,
    output logic [7:0] busIn
);
    logic [7:0] mem [0:255];
    logic [7:0] la;
    initial busIn = 8'h00;
    // latched on the falling edge so the bus may turn to data afterwards
    always @(negedge addrLatchStrobe) la = busAddr[7:0];
    always @(posedge clock) begin
        if (!dataLowWriteStrobe_n) mem[la] <= busOut;
        if (!dataReadStrobe_n) busIn <= mem[la];
        else if (!codeReadStrobe_n) busIn <= ~la;
        else busIn <= ~busIn;
    end
endmodule // ext_mem

//--- external_bus_boot_select_tb.sv
`timescale 1ns/100ps
`include "ext_bus_regs.vh"
module external_bus_boot_select_tb;
    logic clock = 1'h0, nrst = 1'h0, reqValid = 1'h0, bootMemorySelect_n = 1'h0;
    logic [1:0] reqKind = 2'h0;
    logic [19:0] reqAddr = 20'h0;
    logic [7:0] reqWdata = 8'h00;
    wire reqReady, respValid, bootExternal, addrLatchStrobe, busOutEnable;
    wire codeReadStrobe_n, dataReadStrobe_n, dataLowWriteStrobe_n;
    wire [19:0] busAddr, resetVector;
    wire [7:0] busIn, busOut, respData;
    integer errors = 0, comparisons = 0;
    always #5 clock = ~clock;
    external_bus_boot_select u_dut (.clock, .nrst, .reqValid, .reqKind, .reqAddr, .reqWdata,
        .bootMemorySelect_n, .busIn, .reqReady, .reqInternal(), .respValid, .respData,
        .resetVector, .bootExternal, .addrLatchStrobe, .codeReadStrobe_n, .dataReadStrobe_n,
        .dataLowWriteStrobe_n, .busAddr, .busOut, .busOutEnable);
    ext_mem u_mem (.clock, .addrLatchStrobe, .busAddr, .codeReadStrobe_n, .dataReadStrobe_n,
        .dataLowWriteStrobe_n, .busOut, .busIn);
    ////////////////////////////////////////////////////////////////
    task chk(input logic [19:0] s, input logic [19:0] e);
        comparisons++;
        if (s !== e) begin
            errors++;
            $display("wrong value at %0t: %h expected %h", $time, s, e);
        end
    endtask
    task stop_test;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task rst(input logic b);
        integer n;
        nrst = 1'h0;
        bootMemorySelect_n = b;
        repeat (3) @(posedge clock);
        #1 chk({addrLatchStrobe, codeReadStrobe_n, dataReadStrobe_n, dataLowWriteStrobe_n,
            reqReady}, 20'h0e);
        nrst = 1'h1;
        for (n = 0; n < 20 && reqReady !== 1'h1; n++) @(posedge clock) #1;
        bootMemorySelect_n = 1'h0;
        chk(bootExternal, !b);
        chk(resetVector, `RESET_VECTOR);
    endtask
    // st: cycles the wait input is held high; x: bus cycle expected
    task req(input logic [1:0] k, input logic [19:0] a, input logic [7:0] w, d,
        input integer st, input logic x);
        integer n;
        logic ale;
        ale = 1'h0;
        bootMemorySelect_n = st > 0;
        for (n = 0; n < 20 && reqReady !== 1'h1; n++) @(posedge clock) #1;
        {reqValid, reqKind, reqAddr, reqWdata} = {1'h1, k, a, w};
        @(posedge clock) #1 reqValid = 1'h0;
        for (n = 0; n < 60 && respValid !== 1'h1; n++) begin
            ale |= addrLatchStrobe;
            if (n == st) bootMemorySelect_n = 1'h0;
            @(posedge clock) #1;
        end
        chk(ale, x);
        chk(n >= st, 1'h1);
        if (x && k != `KIND_WRITE) chk(respData, d);
    endtask
    task t_int_boot;
        rst(1'h1);
        req(`KIND_CODE, `RESET_VECTOR, 8'h00, 8'h00, 0, 1'h0);
        req(`KIND_CODE, `INT_CODE_LIMIT, 8'h00, 8'hff, 0, 1'h1);
        req(`KIND_WRITE, 20'h00033, 8'ha5, 8'h00, 0, 1'h1);
        req(`KIND_READ, 20'h00033, 8'h00, 8'ha5, 10, 1'h1);
        $display("internal boot test done");
    endtask
    task t_ext_boot;
        rst(1'h0);
        req(`KIND_CODE, 20'h00010, 8'h00, 8'hef, 0, 1'h1);
        $display("external boot test done");
    endtask
    initial begin
        t_int_boot;
        t_ext_boot;
        stop_test;
    end
    initial begin
        #20000;
        errors++;
        stop_test;
    end
endmodule // external_bus_boot_select_tb
